// ===== design/rdd_pkg.sv
// Package with constants for the run direction decoder
`default_nettype none
package rdd_pkg;
  localparam int          TERM_COUNT       = 5;
  localparam int          FUNC_WIDTH       = 6;
  localparam logic [5:0]  FUNC_FORWARD_RUN = 6'h00;
  localparam logic [5:0]  FUNC_REVERSE_RUN = 6'h01;
  localparam logic [5:0]  FUNC_RESET_VALUE = 6'h3F;
  localparam logic [1:0]  SRC_TERMINALS    = 2'h1;
  localparam logic [1:0]  SRC_RESET_VALUE  = 2'h1;
  localparam int          ADDR_WIDTH       = 4;
  localparam logic [3:0]  REG_FUNC_BASE    = 4'h0;
  localparam logic [3:0]  REG_SENSE        = 4'h5;
  localparam logic [3:0]  REG_SOURCE       = 4'h6;
  localparam logic [3:0]  REG_KEYPAD_DIR   = 4'h7;
  localparam logic [3:0]  REG_STATUS       = 4'h8;
  localparam logic [3:0]  REG_TERM_LEVEL   = 4'h9;
  localparam int          STAT_RUN_BIT     = 0;
  localparam int          STAT_REV_BIT     = 1;
  localparam int          STAT_KEYPAD_BIT  = 2;
endpackage
`default_nettype wire

// ===== design/rdd_input_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module rdd_input_sync
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output logic      level_out
);
  logic stage1;
  logic stage2;
  logic stage3;

  // ****************************************
  // Synchroniser chain
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ****************************************
  // Accept a change once two stages agree
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      level_out <= 1'b0;
    else if (stage2 == stage3)
      level_out <= stage3;
  end
endmodule
`default_nettype wire

// ===== design/rdd_top.sv
// Run direction decoder: terminal decode, settings registers, run mode outputs
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Forward input active gives forward run
// [R2] Reverse input active gives reverse run
// [R3] Both run inputs active gives stop
// [R4] Normally-closed open terminal counts as active
// [R5] Keypad direction only steers keypad run key
// [R6] Active run input at power-up starts rotation
// [R7] Five identical terminals, each function select
// [R8] Terminal runs honoured only when source selects terminals
module rdd_top
#(
  parameter int TERMS = rdd_pkg::TERM_COUNT
)
(
  input  wire logic                          CLK_IN,
  input  wire logic                          RST_N_IN,
  input  wire logic [TERMS-1:0]              TERMINAL_IN,
  input  wire logic                          KEYPAD_RUN_IN,
  input  wire logic                          KEYPAD_STOP_IN,
  input  wire logic [rdd_pkg::ADDR_WIDTH-1:0] ADDR_IN,
  input  wire logic [31:0]                   WDATA_IN,
  input  wire logic                          WR_IN,
  input  wire logic                          RD_IN,
  output logic      [31:0]                   RDATA_OUT,
  output logic                               RUN_OUT,
  output logic                               REVERSE_OUT
);
  typedef enum logic [1:0] {MODE_STOP, MODE_FWD, MODE_REV} rdd_mode_t;

  logic [rdd_pkg::FUNC_WIDTH-1:0] input_function_select [TERMS];
  logic [TERMS-1:0]               sense_nc;
  logic [1:0]                     run_command_source;
  logic                           keypad_run_direction_select;
  logic [TERMS-1:0]               term_level;
  logic [TERMS-1:0]               term_active;
  logic                           forward_run_input;
  logic                           reverse_run_input;
  logic                           keypad_latch;
  rdd_mode_t                      next_mode;
  logic [rdd_pkg::FUNC_WIDTH-1:0] wr_func;
  logic                           wr_sense;
  logic                           wr_source;
  logic                           wr_keydir;

  // ****************************************
  // Decode helpers
  // ****************************************
  // True when an index selects the function register of one terminal
  function automatic logic func_reg_hit
  (
    input logic [rdd_pkg::ADDR_WIDTH-1:0] addr,
    input int                             idx
  );
    return addr == rdd_pkg::REG_FUNC_BASE + 4'(idx);
  endfunction

  // True when an active terminal carries the given run function
  function automatic logic func_active
  (
    input logic                           active,
    input logic [rdd_pkg::FUNC_WIDTH-1:0] sel,
    input logic [rdd_pkg::FUNC_WIDTH-1:0] code
  );
    return active && sel == code;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < TERMS; g++)
    begin : gen_sync
      rdd_input_sync u_sync
      (
        .clk_in    (CLK_IN),
        .rst_n_in  (RST_N_IN),
        .pin_in    (TERMINAL_IN[g]),
        .level_out (term_level[g])
      );
    end
  endgenerate

  // ****************************************
  // Settings registers
  // ****************************************
  assign wr_func = WDATA_IN[rdd_pkg::FUNC_WIDTH-1:0];

  // ****************************************
  // Register write decode
  // ****************************************
  assign wr_sense  = WR_IN && ADDR_IN == rdd_pkg::REG_SENSE;
  assign wr_source = WR_IN && ADDR_IN == rdd_pkg::REG_SOURCE;
  assign wr_keydir = WR_IN && ADDR_IN == rdd_pkg::REG_KEYPAD_DIR;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      for (int i = 0; i < TERMS; i++)
        input_function_select[i] <= rdd_pkg::FUNC_RESET_VALUE;
    end
    else if (WR_IN)
    begin
      for (int i = 0; i < TERMS; i++)
        if (func_reg_hit(ADDR_IN, i))
          input_function_select[i] <= wr_func; // [R7]
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sense_nc                    <= '0;
      run_command_source          <= rdd_pkg::SRC_RESET_VALUE;
      keypad_run_direction_select <= 1'b0;
    end
    else
    begin
      if (wr_sense)
        sense_nc <= WDATA_IN[TERMS-1:0]; // [R4]
      if (wr_source)
        run_command_source <= WDATA_IN[1:0]; // [R8]
      if (wr_keydir)
        keypad_run_direction_select <= WDATA_IN[0]; // [R5]
    end
  end

  // ****************************************
  // Terminal decode
  // ****************************************
  always_comb
  begin
    term_active       = term_level ^ sense_nc; // [R4]
    forward_run_input = 1'b0;
    reverse_run_input = 1'b0;
    for (int i = 0; i < TERMS; i++)
    begin
      if (func_active(term_active[i], input_function_select[i], rdd_pkg::FUNC_FORWARD_RUN))
        forward_run_input = 1'b1; // [R7]
      if (func_active(term_active[i], input_function_select[i], rdd_pkg::FUNC_REVERSE_RUN))
        reverse_run_input = 1'b1; // [R7]
    end
  end

  // ****************************************
  // Keypad run latch
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      keypad_latch <= 1'b0;
    else if (run_command_source == rdd_pkg::SRC_TERMINALS || KEYPAD_STOP_IN)
      keypad_latch <= 1'b0;
    else if (KEYPAD_RUN_IN)
      keypad_latch <= 1'b1;
  end

  // ****************************************
  // Run mode selection
  // ****************************************
  always_comb
  begin
    next_mode = MODE_STOP;
    if (run_command_source == rdd_pkg::SRC_TERMINALS) // [R8]
    begin
      case ({forward_run_input, reverse_run_input})
        2'b10:   next_mode = MODE_FWD;  // [R1] [R6]
        2'b01:   next_mode = MODE_REV;  // [R2] [R6]
        2'b11:   next_mode = MODE_STOP; // [R3]
        2'b00:   next_mode = MODE_STOP;
        default: next_mode = MODE_STOP;
      endcase
    end
    else if (keypad_latch)
      next_mode = keypad_run_direction_select ? MODE_REV : MODE_FWD; // [R5]
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      RUN_OUT     <= 1'b0;
      REVERSE_OUT <= 1'b0;
    end
    else
    begin
      RUN_OUT     <= (next_mode != MODE_STOP);
      REVERSE_OUT <= (next_mode == MODE_REV);
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      RDATA_OUT <= '0;
    else if (RD_IN)
    begin
      RDATA_OUT <= '0;
      for (int i = 0; i < TERMS; i++)
        if (func_reg_hit(ADDR_IN, i))
          RDATA_OUT <= {26'h0, input_function_select[i]};
      case (ADDR_IN)
        rdd_pkg::REG_SENSE:      RDATA_OUT <= {{(32-TERMS){1'b0}}, sense_nc};
        rdd_pkg::REG_SOURCE:     RDATA_OUT <= {30'h0, run_command_source};
        rdd_pkg::REG_KEYPAD_DIR: RDATA_OUT <= {31'h0, keypad_run_direction_select};
        rdd_pkg::REG_STATUS:     RDATA_OUT <= {29'h0, keypad_latch, REVERSE_OUT, RUN_OUT};
        rdd_pkg::REG_TERM_LEVEL: RDATA_OUT <= {{(32-TERMS){1'b0}}, term_active};
        default:                 ;
      endcase
    end
    else
      RDATA_OUT <= '0;
  end
endmodule
`default_nettype wire

// ===== verif/rdd_switch_model.sv
// Field switch model driving the terminal pins
`timescale 1ns/1ps
`default_nettype none
module rdd_switch_model
(
  input  wire logic [4:0] closed_in,
  output logic      [4:0] pin_out
);
  // Open contact leaves no voltage
  // Bench opens all contacts before reset ends
  assign pin_out = closed_in;
endmodule
`default_nettype wire

// ===== verif/rdd_chk.sv
// Port checker for the run direction decoder
`timescale 1ns/1ps
`default_nettype none
module rdd_chk
#(
  parameter int TERMS = 5
)
(
  input wire logic             CLK_IN,
  input wire logic             RST_N_IN,
  input wire logic [TERMS-1:0] TERMINAL_IN,
  input wire logic             KEYPAD_RUN_IN,
  input wire logic             KEYPAD_STOP_IN,
  input wire logic [3:0]       ADDR_IN,
  input wire logic [31:0]      WDATA_IN,
  input wire logic             WR_IN,
  input wire logic             RD_IN,
  input wire logic [31:0]      RDATA_OUT,
  input wire logic             RUN_OUT,
  input wire logic             REVERSE_OUT
);
  logic [1:0] src;
  logic [3:0] quiet;
  logic       keyp;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  assign keyp = src != rdd_pkg::SRC_TERMINALS;
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      src <= rdd_pkg::SRC_RESET_VALUE;
    else if (WR_IN && ADDR_IN == rdd_pkg::REG_SOURCE)
      src <= WDATA_IN[1:0];
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
      quiet <= 4'h0;
    else if ($changed(TERMINAL_IN) || WR_IN || KEYPAD_RUN_IN || KEYPAD_STOP_IN)
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  chk_rev_has_run: assert property (REVERSE_OUT |-> RUN_OUT) else $error("rev without run");
  chk_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0) else $error("stray rdata");
  chk_unmapped_zero: assert property ($past(RD_IN) && $past(ADDR_IN) > 4'h9 |-> RDATA_OUT == 32'h0)
    else $error("unmapped read");
  chk_func_width: assert property ($past(RD_IN) && $past(ADDR_IN) < 4'h5 |-> RDATA_OUT[31:6] == 26'h0)
    else $error("func width");
  chk_src_readback: assert property ($past(RD_IN) && $past(ADDR_IN) == 4'h6 |-> RDATA_OUT == {30'h0, $past(src)})
    else $error("source readback");
  chk_out_settled: assert property (quiet > 4'h6 |-> $stable({RUN_OUT, REVERSE_OUT})) else $error("output moved");
  chk_keypad_only: assert property ($rose(RUN_OUT) && keyp && $past(keyp) |-> $past(KEYPAD_RUN_IN, 2))
    else $error("run without key");
  chk_stop_key: assert property (KEYPAD_STOP_IN && !WR_IN && keyp && $past(keyp) |-> ##2 !RUN_OUT)
    else $error("stop ignored");
endmodule
bind rdd_top rdd_chk #(.TERMS(TERMS)) u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .TERMINAL_IN(TERMINAL_IN),
  .KEYPAD_RUN_IN(KEYPAD_RUN_IN), .KEYPAD_STOP_IN(KEYPAD_STOP_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .RUN_OUT(RUN_OUT), .REVERSE_OUT(REVERSE_OUT));
`default_nettype wire

// ===== verif/test_run_direction_decoder.sv
// Testbench for the run direction decoder
`timescale 1ns/1ps
`default_nettype none
module test_run_direction_decoder;
  logic clk = 0, rst_n = 0, kr = 0, ks = 0, wr = 0, rd = 0, run, rev;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [4:0] sw = 5'h0, pins;
  int mismatches = 0, checked = 0;
  always #2.5 clk = ~clk;
  rdd_switch_model u_sw (.closed_in(sw), .pin_out(pins));
  rdd_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .TERMINAL_IN(pins), .KEYPAD_RUN_IN(kr), .KEYPAD_STOP_IN(ks),
    .ADDR_IN(ad), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .RUN_OUT(run), .REVERSE_OUT(rev));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      $display("ERROR %0t seen %h expected %h", $time, s, e);
      mismatches++;
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1;
    ad <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdat, e);
  endtask
  task automatic out(input logic [4:0] s, input logic r, input logic v);
    @(posedge clk);
    sw <= s;
    repeat (6) @(posedge clk);
    #1 chk({30'h0, run, rev}, {30'h0, r, v});
  endtask
  task automatic key(input logic k, input logic r, input logic v);
    @(posedge clk);
    if (k) kr <= 1'h1; else ks <= 1'h1;
    @(posedge clk);
    kr <= 1'h0;
    ks <= 1'h0;
    @(posedge clk);
    #1 chk({30'h0, run, rev}, {30'h0, r, v});
  endtask
  task automatic t_regs;
    rreg(4'h0, 32'h3F);
    rreg(4'h6, 32'h1);
    rreg(4'hF, 32'h0);
  endtask
  task automatic t_terms;
    for (int i = 0; i < 5; i++)
    begin
      wreg(4'(i), 32'h0);
      out(5'h1 << i, 1'h1, 1'h0);
      out(5'h0, 1'h0, 1'h0);
      wreg(4'(i), 32'h3F);
    end
    wreg(4'h0, 32'h0);
    wreg(4'h4, 32'h1);
    wreg(4'h7, 32'h1);
    rreg(4'h7, 32'h1);
    out(5'h01, 1'h1, 1'h0);
    out(5'h11, 1'h0, 1'h0);
    out(5'h10, 1'h1, 1'h1);
    out(5'h00, 1'h0, 1'h0);
  endtask
  task automatic t_nc;
    wreg(4'h5, 32'h1);
    out(5'h00, 1'h1, 1'h0);
    rreg(4'h9, 32'h1);
    rreg(4'h5, 32'h1);
    wreg(4'h6, 32'h2);
    out(5'h00, 1'h0, 1'h0);
    rreg(4'h6, 32'h2);
    key(1'h1, 1'h1, 1'h1);
    rreg(4'h8, 32'h7);
    key(1'h0, 1'h0, 1'h0);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    complete_run;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    t_terms;
    t_nc;
    complete_run;
  end
endmodule
`default_nettype wire
